// ---- core/bsim_brake_seq.sv ----
// holding-brake sequencer with input port function allocator, apb slave
// assumes in_pins are asynchronous; motor_speed comes from the mclk domain
//
// Contract
// - positive servo-on delay: release brake first, excite after the delay
// - negative servo-on delay: excite first, release brake after the delay
// - standard wait flow: brake and excitation drop together at servo-off
// - after servo-off, brake when motor speed falls below the wait speed
// - after servo-off, brake when elapsed time exceeds the wait time
// - after servo-off, brake on whichever of speed or time comes first
// - one hex digit per input port, two four-digit settings, eight ports
// - codes: 0 servo-on, 1 prop switch, 2 fwd OT, 3 rev OT, 4 alarm reset
// - new input mapping applies only after restart; running map unchanged
// - brake timing applies only when a brake output is assigned
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "bsim_regs.svh"

module bsim_brake_seq #(
	parameter int TICK_CYCLES = `BSIM_TICK_CYCLES
) (
	// clock, reset, clock enable
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// motor side
	input wire logic [15:0] motor_speed,
	input wire logic [7:0] in_pins,
	output logic motor_excite_out,
	output logic brake_ctrl_out,
	// allocated input functions
	output logic prop_ctrl_switch_in,
	output logic fwd_overtravel_in,
	output logic rev_overtravel_in,
	output logic alarm_reset_in
);
	// or of all ports mapped to one function code
	function automatic logic fn_hit(input logic [31:0] map,
		input logic [7:0] pins, input logic [3:0] code);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (map[i*4 +: 4] == code && pins[i])
				hit = 1'b1;
		end
		return hit;
	endfunction

	// magnitude of the signed servo-on delay
	function automatic logic [15:0] mag16(input logic [15:0] v);
		return v[15] ? 16'(-v) : v;
	endfunction

	logic [15:0] son_dly_q, son_dly_d, wspeed_q, wspeed_d, wtime_q, wtime_d;
	logic [15:0] map_lo_q, map_lo_d, map_hi_q, map_hi_d;
	logic flow_q, flow_d, bk_asg_q, bk_asg_d;
	logic [31:0] map_q, map_d;
	logic load_q, load_d;
	logic [31:0] prdata_d;
	logic pready_d, pslverr_d;
	logic [7:0] sync1_q, sync2_q;
	logic son_q, son_d, pcs_d, fot_d, rot_d, alm_d;
	logic [31:0] tick_cnt_q, tick_cnt_d;
	logic tick;
	bsim_pkg::bsim_state_t st_q, st_d;
	logic [15:0] tmr_q, tmr_d;
	logic brk_q, brk_d, exc_q, exc_d;
	logic acc, wr, done_wait;

	assign acc = psel && penable && !pready;
	assign wr = acc && pwrite;
	assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));
	// speed below threshold or elapsed ticks past the wait time
	assign done_wait = (motor_speed < wspeed_q)
		|| (17'(tmr_q) + 17'h00001 > 17'(wtime_q));

	// apb register file, one wait state per access
	always_comb begin
		son_dly_d = son_dly_q;
		flow_d = flow_q;
		wspeed_d = wspeed_q;
		wtime_d = wtime_q;
		map_lo_d = map_lo_q;
		map_hi_d = map_hi_q;
		bk_asg_d = bk_asg_q;
		load_d = 1'b0;
		prdata_d = 32'h00000000;
		pready_d = acc;
		pslverr_d = 1'b0;
		if (acc) begin
			unique case (paddr)
			`BSIM_OFF_SON_DLY: begin
				if (wr) son_dly_d = pwdata[15:0];
				prdata_d = {16'h0000, son_dly_q};
			end
			`BSIM_OFF_FLOW: begin
				if (wr) flow_d = pwdata[0];
				prdata_d = {31'h00000000, flow_q};
			end
			`BSIM_OFF_WSPEED: begin
				if (wr) wspeed_d = pwdata[15:0];
				prdata_d = {16'h0000, wspeed_q};
			end
			`BSIM_OFF_WTIME: begin
				if (wr) wtime_d = pwdata[15:0];
				prdata_d = {16'h0000, wtime_q};
			end
			`BSIM_OFF_MAP_LO: begin
				if (wr) map_lo_d = pwdata[15:0];
				prdata_d = {16'h0000, map_lo_q};
			end
			`BSIM_OFF_MAP_HI: begin
				if (wr) map_hi_d = pwdata[15:0];
				prdata_d = {16'h0000, map_hi_q};
			end
			`BSIM_OFF_CTRL: begin
				if (wr) begin
					bk_asg_d = pwdata[`BSIM_CTRL_BK_ASSIGNED];
					load_d = pwdata[`BSIM_CTRL_RESTART];
				end
				prdata_d = {30'h00000000, bk_asg_q, 1'b0};
			end
			`BSIM_OFF_STAT: begin
				prdata_d = {28'h0000000,
					(map_q != {map_hi_q, map_lo_q}),
					son_q, exc_q, brk_q};
			end
			default: pslverr_d = 1'b1; // unmapped
			endcase
		end
	end

	// running input map, reloaded only at restart
	always_comb begin
		map_d = load_q ? {map_hi_q, map_lo_q} : map_q;
	end

	// port function decode from synchronised pins
	always_comb begin
		son_d = fn_hit(map_q, sync2_q, `BSIM_FN_SERVO_ON);
		pcs_d = fn_hit(map_q, sync2_q, `BSIM_FN_PROP_CTRL);
		fot_d = fn_hit(map_q, sync2_q, `BSIM_FN_FWD_OT);
		rot_d = fn_hit(map_q, sync2_q, `BSIM_FN_REV_OT);
		alm_d = fn_hit(map_q, sync2_q, `BSIM_FN_ALM_RST);
		tick_cnt_d = tick ? 32'h00000000 : tick_cnt_q + 32'h00000001;
	end

	// brake sequencer
	always_comb begin
		st_d = st_q;
		tmr_d = tmr_q;
		brk_d = brk_q;
		exc_d = exc_q;
		unique case (st_q)
		bsim_pkg::ST_OFF: begin
			tmr_d = 16'h0000;
			if (son_q) begin
				if (!bk_asg_q || son_dly_q == 16'h0000) begin
					brk_d = 1'b1;
					exc_d = 1'b1;
					st_d = bsim_pkg::ST_RUN;
				end else if (!son_dly_q[15]) begin
					brk_d = 1'b1;
					st_d = bsim_pkg::ST_WAIT_EXC;
				end else begin
					exc_d = 1'b1;
					st_d = bsim_pkg::ST_WAIT_BRK;
				end
			end
		end
		bsim_pkg::ST_WAIT_EXC, bsim_pkg::ST_WAIT_BRK: begin
			if (!son_q) begin
				brk_d = 1'b0;
				exc_d = 1'b0;
				st_d = bsim_pkg::ST_OFF;
			end else if (tick) begin
				tmr_d = tmr_q + 16'h0001;
				if (tmr_q + 16'h0001 >= mag16(son_dly_q)) begin
					brk_d = 1'b1;
					exc_d = 1'b1;
					st_d = bsim_pkg::ST_RUN;
				end
			end
		end
		bsim_pkg::ST_RUN: begin
			tmr_d = 16'h0000;
			if (!son_q) begin
				exc_d = 1'b0;
				if (!bk_asg_q || !flow_q) begin
					brk_d = 1'b0;
					st_d = bsim_pkg::ST_OFF;
				end else begin
					st_d = bsim_pkg::ST_STOP_WAIT;
				end
			end
		end
		bsim_pkg::ST_STOP_WAIT: begin
			if (tick) begin
				tmr_d = tmr_q + 16'h0001;
				if (done_wait) begin
					brk_d = 1'b0;
					st_d = bsim_pkg::ST_OFF;
				end
			end
		end
		endcase
	end

	// all state registers, frozen while ce is low
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			son_dly_q <= `BSIM_RST_SON_DLY;
			flow_q <= `BSIM_RST_FLOW;
			wspeed_q <= `BSIM_RST_WSPEED;
			wtime_q <= `BSIM_RST_WTIME;
			map_lo_q <= `BSIM_RST_MAP_LO;
			map_hi_q <= `BSIM_RST_MAP_HI;
			bk_asg_q <= `BSIM_RST_BK_ASSIGNED;
			map_q <= {`BSIM_RST_MAP_HI, `BSIM_RST_MAP_LO};
			load_q <= 1'b0;
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			sync1_q <= 8'h00;
			sync2_q <= 8'h00;
			son_q <= 1'b0;
			prop_ctrl_switch_in <= 1'b0;
			fwd_overtravel_in <= 1'b0;
			rev_overtravel_in <= 1'b0;
			alarm_reset_in <= 1'b0;
			tick_cnt_q <= 32'h00000000;
			st_q <= bsim_pkg::ST_OFF;
			tmr_q <= 16'h0000;
			brake_ctrl_out <= 1'b0;
			motor_excite_out <= 1'b0;
		end else if (ce) begin
			son_dly_q <= son_dly_d;
			flow_q <= flow_d;
			wspeed_q <= wspeed_d;
			wtime_q <= wtime_d;
			map_lo_q <= map_lo_d;
			map_hi_q <= map_hi_d;
			bk_asg_q <= bk_asg_d;
			map_q <= map_d;
			load_q <= load_d;
			prdata <= prdata_d;
			pready <= pready_d;
			pslverr <= pslverr_d;
			sync1_q <= in_pins;
			sync2_q <= sync1_q;
			son_q <= son_d;
			prop_ctrl_switch_in <= pcs_d;
			fwd_overtravel_in <= fot_d;
			rev_overtravel_in <= rot_d;
			alarm_reset_in <= alm_d;
			tick_cnt_q <= tick_cnt_d;
			st_q <= st_d;
			tmr_q <= tmr_d;
			brake_ctrl_out <= brk_d;
			motor_excite_out <= exc_d;
		end
	end
	assign brk_q = brake_ctrl_out;
	assign exc_q = motor_excite_out;

	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	AST_POS_BRK_FIRST: assert property (
		ce && st_q == bsim_pkg::ST_OFF && son_q && bk_asg_q
		&& !son_dly_q[15] && son_dly_q != 16'h0000
		|=> brake_ctrl_out && !motor_excite_out)
		else $error("brake not released before excitation");
	AST_NEG_EXC_FIRST: assert property (
		ce && st_q == bsim_pkg::ST_OFF && son_q && bk_asg_q && son_dly_q[15]
		|=> motor_excite_out && !brake_ctrl_out)
		else $error("excitation not first on negative delay");
	AST_STD_FLOW: assert property (
		ce && st_q == bsim_pkg::ST_RUN && !son_q && !flow_q
		|=> !brake_ctrl_out && !motor_excite_out)
		else $error("standard flow did not drop both together");
	AST_SPEED_BRK: assert property (
		ce && st_q == bsim_pkg::ST_STOP_WAIT && tick && motor_speed < wspeed_q
		|=> !brake_ctrl_out)
		else $error("brake late after speed fell");
	AST_TIME_BRK: assert property (
		ce && st_q == bsim_pkg::ST_STOP_WAIT && tick && tmr_q >= wtime_q
		|=> !brake_ctrl_out)
		else $error("brake late after wait time");
	AST_NOT_EARLY: assert property (
		ce && st_q == bsim_pkg::ST_STOP_WAIT && !done_wait
		|=> brake_ctrl_out)
		else $error("brake engaged before either condition");
	AST_SERVO_MAP: assert property (
		ce && map_q[3:0] == `BSIM_FN_SERVO_ON && sync2_q[0]
		|=> son_q)
		else $error("port 0 servo-on not decoded");
	AST_MAP_HOLD: assert property (
		ce && !load_q |=> map_q == $past(map_q))
		else $error("running map changed without restart");
	AST_NO_BK_ASSIGN: assert property (
		ce && st_q == bsim_pkg::ST_OFF && son_q && !bk_asg_q
		|=> brake_ctrl_out && motor_excite_out)
		else $error("timing applied with no brake output assigned");
	AST_TIMER_STEP: assert property (
		ce && st_q == bsim_pkg::ST_STOP_WAIT && tick && !done_wait
		|=> tmr_q == $past(tmr_q) + 16'h0001)
		else $error("wait timer did not advance");
	AST_APB_ANSWER: assert property (
		ce && psel && penable && !pready |=> pready)
		else $error("apb access not answered");

	COV_POS_ON: cover property (st_q == bsim_pkg::ST_WAIT_EXC
		##[1:1000] st_q == bsim_pkg::ST_RUN);
	COV_NEG_ON: cover property (st_q == bsim_pkg::ST_WAIT_BRK
		##[1:1000] st_q == bsim_pkg::ST_RUN);
	COV_STOP_WAIT: cover property (st_q == bsim_pkg::ST_STOP_WAIT
		##1 st_q == bsim_pkg::ST_OFF);
	COV_RELOAD: cover property (load_q && map_q != {map_hi_q, map_lo_q});
endmodule // bsim_brake_seq

// ---- core/bsim_pkg.sv ----
// types shared by the brake sequencer and input allocator
// assumes the constants header is included by users that need numbers
package bsim_pkg;
	// brake sequencer states
	typedef enum logic [2:0] {
		ST_OFF,
		ST_WAIT_EXC,
		ST_WAIT_BRK,
		ST_RUN,
		ST_STOP_WAIT
	} bsim_state_t;
endpackage

// ---- core/bsim_regs.svh ----
// register offsets, field positions, reset values and function codes
// for the brake sequencer and input allocator; definitions only
`ifndef BSIM_REGS_SVH
`define BSIM_REGS_SVH

// apb byte offsets
`define BSIM_OFF_SON_DLY 8'h00
`define BSIM_OFF_FLOW 8'h04
`define BSIM_OFF_WSPEED 8'h08
`define BSIM_OFF_WTIME 8'h0C
`define BSIM_OFF_MAP_LO 8'h10
`define BSIM_OFF_MAP_HI 8'h14
`define BSIM_OFF_CTRL 8'h18
`define BSIM_OFF_STAT 8'h1C

// control register fields
`define BSIM_CTRL_RESTART 0
`define BSIM_CTRL_BK_ASSIGNED 1

// status register fields
`define BSIM_STAT_BRAKE 0
`define BSIM_STAT_EXCITE 1
`define BSIM_STAT_SERVO_ON 2
`define BSIM_STAT_MAP_PEND 3

// reset values
`define BSIM_RST_SON_DLY 16'h0000
`define BSIM_RST_FLOW 1'b0
`define BSIM_RST_WSPEED 16'h0064
`define BSIM_RST_WTIME 16'h01F4
`define BSIM_RST_MAP_LO 16'h3210
`define BSIM_RST_MAP_HI 16'hFFF4
`define BSIM_RST_BK_ASSIGNED 1'b1

// input function codes
`define BSIM_FN_SERVO_ON 4'h0
`define BSIM_FN_PROP_CTRL 4'h1
`define BSIM_FN_FWD_OT 4'h2
`define BSIM_FN_REV_OT 4'h3
`define BSIM_FN_ALM_RST 4'h4

// control cycle: 1 ms at 50 MHz
`define BSIM_CTRL_PERIOD_NS 1000000
`define BSIM_CLK_PERIOD_NS 20
`define BSIM_TICK_CYCLES (`BSIM_CTRL_PERIOD_NS / `BSIM_CLK_PERIOD_NS)

`endif

// ---- verification/bsim_motor_model.sv ----
// behavioural motor with holding brake: speed follows excitation
// assumes excite and brake release levels come from the sequencer
`timescale 1ns/1ps
module bsim_motor_model (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// drive side
	input wire logic excite,
	input wire logic brake_rel,
	// feedback
	output logic [15:0] motor_speed
);
	// full speed while excited, coasts down while the brake is released
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			motor_speed <= 16'h0000;
		else if (excite)
			motor_speed <= 16'h0200;
		else if (!brake_rel)
			motor_speed <= 16'h0000; // engaged brake stops the shaft
		else if (motor_speed >= 16'h0010)
			motor_speed <= motor_speed - 16'h0010;
		else
			motor_speed <= 16'h0000;
	end
endmodule // bsim_motor_model

// ---- verification/tb_top.sv ----
// self-checking bench for the brake sequencer and input allocator
// assumes the motor model on the motor side and a tick of 4 mclk
`timescale 1ns/1ps
`include "bsim_regs.svh"
module tb_top;
	logic mclk, rst, ce, psel, penable, pwrite, pready, pslverr, rerr;
	logic [7:0] paddr, in_pins;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] motor_speed;
	logic excite, brake, prop, fwd, rev, alm;
	int fail_count = 0;
	int samples_checked = 0;
	int c;

	bsim_brake_seq #(.TICK_CYCLES(4)) DUT (.mclk(mclk), .rst(rst),
		.ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .motor_speed(motor_speed), .in_pins(in_pins),
		.motor_excite_out(excite), .brake_ctrl_out(brake),
		.prop_ctrl_switch_in(prop), .fwd_overtravel_in(fwd),
		.rev_overtravel_in(rev), .alarm_reset_in(alm));
	bsim_motor_model motor (.mclk(mclk), .rst(rst), .excite(excite),
		.brake_rel(brake), .motor_speed(motor_speed));

	// clock generator
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// compare and count
	task automatic chk(input logic [31:0] got, exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		// look at the settled answer mid-cycle, commit at the next rise
		@(negedge mclk);
		while (pready !== 1'b1)
			@(negedge mclk);
		rd = prdata;
		rerr = pslverr;
		@(posedge mclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask

	// count falling edges until brake (0) or excite (1) shows a level
	task automatic wait_lvl(input int s, input logic v, output int n);
		n = 0;
		@(negedge mclk);
		while ((s ? excite : brake) !== v && n < 200) begin
			@(negedge mclk);
			n++;
		end
	endtask

	// register reset values and an unmapped address
	task automatic t_regs;
		apb(0, `BSIM_OFF_MAP_LO, 0);
		chk(rd, 32'h3210, "map low reset");
		apb(0, `BSIM_OFF_MAP_HI, 0);
		chk(rd, 32'hFFF4, "map high reset");
		apb(0, `BSIM_OFF_CTRL, 0);
		chk(rd, 32'h0002, "ctrl reset");
		apb(0, 8'h20, 0);
		chk(rerr, 1'b1, "unmapped address");
		$display("register test done");
	endtask

	// servo-on ordering by sign of delay, then immediate braking
	task automatic t_son(input logic [15:0] d, input int f);
		apb(1, `BSIM_OFF_SON_DLY, {16'h0000, d});
		in_pins[0] <= 1'b1;
		wait_lvl(f, 1'b1, c);
		chk(f ? brake : excite, 1'b0, "order at servo-on");
		wait_lvl(1 - f, 1'b1, c);
		chk(c >= 8 && c <= 13, 1, "servo-on delay");
		@(posedge mclk);
		in_pins[0] <= 1'b0;
		wait_lvl(1, 1'b0, c);
		chk(brake, 1'b0, "brake with servo-off");
		$display("servo-on test done");
	endtask

	// wait flow: brake on speed or on time after servo-off
	task automatic t_wait(input logic [15:0] sp, tm, input int lo, hi);
		apb(1, `BSIM_OFF_SON_DLY, 0);
		apb(1, `BSIM_OFF_FLOW, 1);
		apb(1, `BSIM_OFF_WSPEED, {16'h0000, sp});
		apb(1, `BSIM_OFF_WTIME, {16'h0000, tm});
		in_pins[0] <= 1'b1;
		wait_lvl(1, 1'b1, c);
		@(posedge mclk);
		in_pins[0] <= 1'b0;
		wait_lvl(1, 1'b0, c);
		wait_lvl(0, 1'b0, c);
		chk(c >= lo && c <= hi, 1, "brake wait span");
		if (sp != 0)
			chk(motor_speed < sp, 1, "speed at braking");
		$display("wait flow test done");
	endtask

	// brake timing ignored while no brake output is assigned
	task automatic t_noasg;
		apb(1, `BSIM_OFF_CTRL, 0);
		apb(1, `BSIM_OFF_SON_DLY, 3);
		in_pins[0] <= 1'b1;
		wait_lvl(0, 1'b1, c);
		chk(excite, 1'b1, "delay ignored");
		@(posedge mclk);
		in_pins[0] <= 1'b0;
		wait_lvl(0, 1'b0, c);
		chk(excite, 1'b0, "wait ignored");
		$display("unassigned test done");
	endtask

	// function codes, then a new map pending until restart
	task automatic t_map;
		@(posedge mclk);
		for (int i = 1; i < 5; i++) begin
			in_pins <= 8'h01 << i;
			repeat (6) @(posedge mclk);
			chk({alm, rev, fwd, prop}, 4'h1 << (i - 1), "decode");
		end
		apb(1, `BSIM_OFF_MAP_LO, 32'h3240);
		apb(0, `BSIM_OFF_STAT, 0);
		chk(rd[3], 1'b1, "map pending");
		in_pins <= 8'h02;
		repeat (6) @(posedge mclk);
		chk({alm, prop}, 2'h1, "old map runs");
		apb(1, `BSIM_OFF_CTRL, 3);
		repeat (6) @(posedge mclk);
		chk({alm, prop}, 2'h2, "new map after restart");
		// clock enable low must freeze the decoded outputs
		ce <= 1'b0;
		in_pins <= 8'h00;
		repeat (6) @(posedge mclk);
		chk({alm, prop}, 2'h2, "frozen while ce low");
		ce <= 1'b1;
		repeat (6) @(posedge mclk);
		chk({alm, prop}, 2'h0, "runs again after ce");
		$display("map test done");
	endtask

	// verdict
	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// watchdog
	initial begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		test_done;
	end

	// main sequence
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		in_pins = 8'h00;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		t_regs;
		t_son(16'h0003, 0);
		t_son(16'hFFFD, 1);
		t_wait(16'h0064, 16'h0FFF, 24, 40);
		t_wait(16'h0000, 16'h0005, 20, 30);
		t_noasg;
		t_map;
		test_done;
	end
endmodule // tb_top
